// ### hdl/fgs_params.svh
// offsets, field positions, reset values and command codes of the guard
// assumes a 16-bit cpu address space and 8-bit data
`ifndef FGS_PARAMS_SVH
`define FGS_PARAMS_SVH

// ----------------------------------------------------------------------
// address map
// ----------------------------------------------------------------------
`define FGS_FLASH_BASE    16'h8000
`define FGS_RAM_BASE      16'h0080
`define FGS_RAM_LAST      16'h107f
`define FGS_KEY_BASE      16'hffb0
`define FGS_KEY_LAST      16'hffb7
`define FGS_NONVOLATILE_PROTECTION_BYTE_ADDR   16'hffbd
`define FGS_NONVOLATILE_OPTION_BYTE_ADDR    16'hffbf
`define FGS_DIV_ADDR      16'h1820
`define FGS_OPT_ADDR      16'h1821
`define FGS_CFG_ADDR      16'h1823
`define FGS_PROT_ADDR     16'h1824
`define FGS_STAT_ADDR     16'h1825
`define FGS_CMD_ADDR      16'h1826

// ----------------------------------------------------------------------
// vector window
// ----------------------------------------------------------------------
`define FGS_VEC_FIRST     16'hffc0
`define FGS_VEC_LAST      16'hfffd

// ----------------------------------------------------------------------
// field positions and field values
// ----------------------------------------------------------------------
`define FGS_DIVISOR_LOADED_FLAG_BIT     7
`define FGS_STAT_CBEF     7
`define FGS_STAT_PVIOL    5
`define FGS_STAT_ACCERR   4
`define FGS_STAT_BUSY     2
`define FGS_CFG_KEY_ACCESS_BIT    5
`define FGS_OPT_BACKDOOR_KEY_ENABLE     7
`define FGS_OPT_NORED     6
`define FGS_PROT_DIS      0
`define FGS_UNSECURE      2'b10
`define FGS_ALL_OPEN      7'h7f

// ----------------------------------------------------------------------
// command codes
// ----------------------------------------------------------------------
`define FGS_CMD_BLANK     8'h05
`define FGS_CMD_BYTE      8'h20
`define FGS_CMD_BURST     8'h25
`define FGS_CMD_PAGE      8'h40
`define FGS_CMD_MASS      8'h41

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define FGS_RST_BYTE      8'h00
`define FGS_RST_ADDR      16'h0000

`endif

// ### hdl/fgs_pkg.sv
// types shared by the guard and its helpers
// assumes fgs_params.svh is on the include path
package fgs_pkg;
`include "fgs_params.svh"

   // one bus cycle from the cpu or the debug controller
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
      logic        from_debug;
      logic        exec_secure;
   } fgs_bus_type;

   // command handed to the sequencer
   typedef struct packed {
      logic [7:0]  cmd;
      logic [15:0] addr;
      logic [7:0]  data;
   } fgs_cmd_type;

   // command sequence progress
   typedef enum logic [1:0] {
      FGS_IDLE,
      FGS_GOT_ADDR,
      FGS_GOT_CMD
   } fgs_seq_type;

   // last unprotected address from the boundary bits
   function automatic logic [15:0] fgs_last_open(input logic [6:0] protect_boundary_bits);
      fgs_last_open = {protect_boundary_bits, 9'h1ff};
   endfunction

endpackage

// ### hdl/fgs_key_check.sv
// backdoor key comparator: eight bytes in ascending order
// assumes the parent arms it when key access is set
module fgs_key_check
(
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        rst_b_in,
   // control
   input  wire logic        arm_in,
   input  wire logic        wr_in,
   input  wire logic [2:0]  index_in,
   input  wire logic [7:0]  data_in,
   input  wire logic [63:0] key_in,
   // result
   output logic             match_out
);
   import fgs_pkg::*;

   logic [3:0] next_q;
   logic       ok_q;

   // --------------------------------------------------------------------
   // byte order and compare
   // --------------------------------------------------------------------
   // a byte out of order spoils the whole entry until re-armed
   always_ff @(posedge clock_in)
   begin
      if (!rst_b_in || arm_in)
      begin
         next_q <= 4'h0;
         ok_q   <= 1'b1;
      end
      else if (wr_in)
      begin
         if (next_q[3] || index_in != next_q[2:0] ||
             data_in != key_in[{index_in, 3'b000} +: 8])
            ok_q <= 1'b0;
         if (!next_q[3])
            next_q <= next_q + 4'h1;
      end
   end

   // all eight seen and every one equal
   assign match_out = ok_q && next_q[3];

endmodule

// ### hdl/fgs_vector_redirect.sv
// vector fetch redirection below the protected boundary
// assumes protection and option bytes are already loaded
`include "fgs_params.svh"
module fgs_vector_redirect
(
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        rst_b_in,
   // settings
   input  wire logic [7:0]  prot_in,
   input  wire logic        nored_in,
   // fetch
   input  wire logic        fetch_in,
   input  wire logic [15:0] addr_in,
   output logic [15:0]      addr_out
);
   import fgs_pkg::*;

   logic [15:0] addr_q;
   logic        some_prot;
   logic        in_window;

   // some but not all of flash protected, redirect allowed
   assign some_prot = !prot_in[`FGS_PROT_DIS] && !nored_in &&
                      prot_in[7:1] != `FGS_ALL_OPEN &&
                      fgs_last_open(prot_in[7:1]) >= `FGS_FLASH_BASE;
   // reset vector sits above the window, never moved
   assign in_window = addr_in >= `FGS_VEC_FIRST &&
                      addr_in <= `FGS_VEC_LAST;

   // --------------------------------------------------------------------
   // registered fetch address
   // --------------------------------------------------------------------
   always_ff @(posedge clock_in)
   begin
      if (!rst_b_in)
         addr_q <= `FGS_RST_ADDR;
      else if (fetch_in && some_prot && in_window)
         addr_q <= {prot_in[7:1], addr_in[8:0]};
      else if (fetch_in)
         addr_q <= addr_in;
   end

   assign addr_out = addr_q;

endmodule

// ### hdl/fgs_guard.sv
// flash guard: command protocol checker, block protection, security
// assumes one 40 MHz bus clock, synchronous reset and a sequencer that
// reports busy while it programs or erases
`include "fgs_params.svh"

module fgs_guard
(
   // clock and reset
   input  wire logic              clock_in,
   input  wire logic              rst_b_in,
   // cpu and debug bus
   input  wire fgs_pkg::fgs_bus_type bus_in,
   output logic [7:0]             rd_data_out,
   output logic                   mem_block_out,
   // nonvolatile bytes
   input  wire logic [7:0]        nv_prot_in,
   input  wire logic [7:0]        nv_opt_in,
   input  wire logic [63:0]       nv_key_in,
   // sequencer
   output fgs_pkg::fgs_cmd_type   seq_cmd_out,
   output logic                   seq_launch_out,
   output logic                   seq_abort_out,
   input  wire logic              seq_busy_in,
   input  wire logic              seq_done_in,
   input  wire logic              blank_ok_in,
   // system
   input  wire logic              stop_in,
   input  wire logic              vec_fetch_in,
   input  wire logic [15:0]       vec_addr_in,
   output logic [15:0]            vec_addr_out,
   output logic                   secure_out,
   output logic                   prot_active_out
);
   import fgs_pkg::*;

   // --------------------------------------------------------------------
   // state
   // --------------------------------------------------------------------
   fgs_seq_type seq_q;
   fgs_seq_type seq_d;
   fgs_cmd_type cmd_q;
   fgs_cmd_type launch_cmd_q;
   logic [6:0]  div_q;
   logic        divisor_loaded_flag_q;
   logic [7:0]  prot_q;
   logic [7:0]  opt_q;
   logic        key_access_bit_q;
   logic        cbef_q;
   logic        accerr_q;
   logic        pviol_q;
   logic        launch_q;
   logic        abort_q;
   logic        load_q;
   logic [7:0]  rd_q;

   // --------------------------------------------------------------------
   // decode
   // --------------------------------------------------------------------
   logic wr_div;
   logic wr_opt;
   logic wr_cfg;
   logic wr_prot;
   logic wr_stat;
   logic wr_cmd;
   logic wr_ctrl;
   logic is_flash;
   logic is_ram;
   logic is_key;
   logic arr_wr;
   logic key_wr;
   logic secured;
   logic prot_en;
   logic cmd_bad;
   logic cmd_locked;
   logic stop_abort;
   logic err_event;
   logic launch_ok;
   logic launch_try;
   logic prot_refuse;
   logic key_match;
   logic key_close;

   // bus address decode
   assign wr_div   = bus_in.wr && bus_in.addr == `FGS_DIV_ADDR;
   assign wr_opt   = bus_in.wr && bus_in.addr == `FGS_OPT_ADDR;
   assign wr_cfg   = bus_in.wr && bus_in.addr == `FGS_CFG_ADDR;
   assign wr_prot  = bus_in.wr && bus_in.addr == `FGS_PROT_ADDR;
   assign wr_stat  = bus_in.wr && bus_in.addr == `FGS_STAT_ADDR;
   assign wr_cmd   = bus_in.wr && bus_in.addr == `FGS_CMD_ADDR;
   assign wr_ctrl  = wr_div || wr_opt || wr_cfg || wr_prot ||
                     wr_stat || wr_cmd;
   assign is_flash = bus_in.addr >= `FGS_FLASH_BASE;
   assign is_ram   = bus_in.addr >= `FGS_RAM_BASE &&
                     bus_in.addr <= `FGS_RAM_LAST;
   assign is_key   = bus_in.addr >= `FGS_KEY_BASE &&
                     bus_in.addr <= `FGS_KEY_LAST;

   // only secure code may enter the key
   assign key_wr = bus_in.wr && is_key && key_access_bit_q && opt_q[`FGS_OPT_BACKDOOR_KEY_ENABLE]
                   && bus_in.exec_secure && !bus_in.from_debug;
   assign arr_wr = bus_in.wr && is_flash && !key_wr;

   // only one-zero means unsecured, erased reads secure
   assign secured = opt_q[1:0] != `FGS_UNSECURE;
   // disable bit at zero enables protection
   assign prot_en = !prot_q[`FGS_PROT_DIS];

   // untrusted access to secure memory is blocked
   assign mem_block_out = secured && (bus_in.wr || bus_in.rd) &&
                          (is_flash || is_ram) &&
                          (bus_in.from_debug || !bus_in.exec_secure);

   // --------------------------------------------------------------------
   // command checks
   // --------------------------------------------------------------------
   // legal codes and what they mean
   always_comb
   begin
      case (bus_in.wdata)
         `FGS_CMD_BLANK, `FGS_CMD_BYTE, `FGS_CMD_BURST,
         `FGS_CMD_PAGE, `FGS_CMD_MASS: cmd_bad = 1'b0;
         default:                      cmd_bad = 1'b1;
      endcase
   end

   // secured debug path limited to blank and mass
   assign cmd_locked = bus_in.from_debug && secured &&
                       (bus_in.wdata == `FGS_CMD_BYTE ||
                        bus_in.wdata == `FGS_CMD_BURST ||
                        bus_in.wdata == `FGS_CMD_PAGE);

   assign stop_abort = stop_in && seq_busy_in;

   // protocol violation per sequence step
   always_comb
   begin
      err_event = stop_abort;
      case (seq_q)
         FGS_IDLE:
         begin
            if (arr_wr && !accerr_q && (!divisor_loaded_flag_q || !cbef_q))
               err_event = 1'b1;
            if (wr_cmd)
               err_event = 1'b1;
         end
         FGS_GOT_ADDR:
         begin
            // only one array write per command
            if (arr_wr)
               err_event = 1'b1;
            // only the command register may follow
            if (wr_ctrl && !wr_cmd)
               err_event = 1'b1;
            if (wr_cmd && (cmd_bad || cmd_locked))
               err_event = 1'b1;
         end
         FGS_GOT_CMD:
         begin
            // only one command write per command
            if (arr_wr || wr_cmd)
               err_event = 1'b1;
            if (wr_ctrl && !wr_stat)
               err_event = 1'b1;
            if (wr_stat && !bus_in.wdata[`FGS_STAT_CBEF])
               err_event = 1'b1;
         end
         default: err_event = 1'b1;
      endcase
   end

   // launch attempt from a complete sequence
   assign launch_try = seq_q == FGS_GOT_CMD && wr_stat &&
                       bus_in.wdata[`FGS_STAT_CBEF] && !err_event;

   // program and erase refused inside protected area
   // boundary compare uses the all-ones fill
   always_comb
   begin
      prot_refuse = 1'b0;
      if (prot_en && cmd_q.cmd != `FGS_CMD_BLANK)
      begin
         if (cmd_q.cmd == `FGS_CMD_MASS)
            prot_refuse = prot_q[7:1] != `FGS_ALL_OPEN;
         else
            prot_refuse = cmd_q.addr > fgs_last_open(prot_q[7:1]);
      end
   end

   // nothing launches while access error stands
   assign launch_ok = launch_try && !prot_refuse && !accerr_q;

   // --------------------------------------------------------------------
   // sequence state
   // --------------------------------------------------------------------
   always_comb
   begin
      seq_d = seq_q;
      case (seq_q)
         FGS_IDLE:
            // array writes ignored while error set
            if (arr_wr && !accerr_q && divisor_loaded_flag_q && cbef_q && !err_event)
               seq_d = FGS_GOT_ADDR;
         FGS_GOT_ADDR:
            if (err_event)
               seq_d = FGS_IDLE;
            else if (wr_cmd)
               seq_d = FGS_GOT_CMD;
         FGS_GOT_CMD:
            if (err_event || launch_try)
               seq_d = FGS_IDLE;
         default: seq_d = FGS_IDLE;
      endcase
   end

   always_ff @(posedge clock_in)
   begin
      if (!rst_b_in)
         seq_q <= FGS_IDLE;
      else
         seq_q <= seq_d;
   end

   // latched address, data and command
   always_ff @(posedge clock_in)
   begin
      if (!rst_b_in)
         cmd_q <= '0;
      else if (seq_q == FGS_IDLE && seq_d == FGS_GOT_ADDR)
      begin
         cmd_q.addr <= bus_in.addr;
         cmd_q.data <= bus_in.wdata;
      end
      else if (seq_q == FGS_GOT_ADDR && seq_d == FGS_GOT_CMD)
         cmd_q.cmd <= bus_in.wdata;
   end

   // --------------------------------------------------------------------
   // sequencer handoff
   // --------------------------------------------------------------------
   always_ff @(posedge clock_in)
   begin
      if (!rst_b_in)
      begin
         launch_cmd_q <= '0;
         launch_q     <= 1'b0;
         abort_q      <= 1'b0;
      end
      else
      begin
         launch_q <= launch_ok;
         abort_q  <= stop_abort;
         if (launch_ok)
            launch_cmd_q <= cmd_q;
      end
   end

   // buffer empty: cleared at launch, refilled at done or abort
   always_ff @(posedge clock_in)
   begin
      if (!rst_b_in)
         cbef_q <= 1'b1;
      else if (launch_ok)
         cbef_q <= 1'b0;
      else if (seq_done_in || abort_q)
         cbef_q <= 1'b1;
   end

   // --------------------------------------------------------------------
   // status flags
   // --------------------------------------------------------------------
   // cleared only by a one; a new error wins the same cycle
   always_ff @(posedge clock_in)
   begin
      if (!rst_b_in)
         accerr_q <= 1'b0;
      else if (err_event)
         accerr_q <= 1'b1;
      else if (wr_stat && bus_in.wdata[`FGS_STAT_ACCERR])
         accerr_q <= 1'b0;
   end

   // protection refusal flag, set wins over clear
   always_ff @(posedge clock_in)
   begin
      if (!rst_b_in)
         pviol_q <= 1'b0;
      else if (launch_try && prot_refuse)
         pviol_q <= 1'b1;
      else if (wr_stat && bus_in.wdata[`FGS_STAT_PVIOL])
         pviol_q <= 1'b0;
   end

   // --------------------------------------------------------------------
   // divider, written once
   // --------------------------------------------------------------------
   // first write while no access error stands sets loaded flag whatever the data
   always_ff @(posedge clock_in)
   begin
      if (!rst_b_in)
      begin
         div_q   <= 7'h00;
         divisor_loaded_flag_q <= 1'b0;
      end
      else if (wr_div && !divisor_loaded_flag_q && !accerr_q)
      begin
         div_q   <= bus_in.wdata[6:0];
         divisor_loaded_flag_q <= 1'b1;
      end
   end

   // --------------------------------------------------------------------
   // nonvolatile copies and security
   // --------------------------------------------------------------------
   // bytes are caught on the cycle after reset releases
   always_ff @(posedge clock_in)
   begin
      if (!rst_b_in)
         load_q <= 1'b1;
      else
         load_q <= 1'b0;
   end

   // protection loaded at reset, debug writes only
   always_ff @(posedge clock_in)
   begin
      if (!rst_b_in)
         prot_q <= `FGS_RST_BYTE;
      else if (load_q)
         prot_q <= nv_prot_in;
      else if (wr_prot && bus_in.from_debug)
         prot_q <= bus_in.wdata;
   end

   // key match on the falling edge of key access
   assign key_close = wr_cfg && key_access_bit_q && !bus_in.wdata[`FGS_CFG_KEY_ACCESS_BIT];

   // full match unsecures until next reset
   // blank check pass unsecures until next reset
   always_ff @(posedge clock_in)
   begin
      if (!rst_b_in)
         opt_q <= `FGS_RST_BYTE;
      else if (load_q)
         opt_q <= nv_opt_in;
      else if ((key_close && key_match && opt_q[`FGS_OPT_BACKDOOR_KEY_ENABLE]) ||
               (seq_done_in && blank_ok_in &&
                launch_cmd_q.cmd == `FGS_CMD_BLANK))
         opt_q[1:0] <= `FGS_UNSECURE;
   end

   // key access bit; debug may set it too, but key_wr refuses key bytes from debug
   always_ff @(posedge clock_in)
   begin
      if (!rst_b_in)
         key_access_bit_q <= 1'b0;
      else if (wr_cfg)
         key_access_bit_q <= bus_in.wdata[`FGS_CFG_KEY_ACCESS_BIT];
   end

   fgs_key_check u_key
   (
      .clock_in  (clock_in),
      .rst_b_in  (rst_b_in),
      .arm_in    (wr_cfg && !key_access_bit_q),
      .wr_in     (key_wr),
      .index_in  (bus_in.addr[2:0]),
      .data_in   (bus_in.wdata),
      .key_in    (nv_key_in),
      .match_out (key_match)
   );

   fgs_vector_redirect u_vec
   (
      .clock_in  (clock_in),
      .rst_b_in  (rst_b_in),
      .prot_in   (prot_q),
      .nored_in  (opt_q[`FGS_OPT_NORED]),
      .fetch_in  (vec_fetch_in),
      .addr_in   (vec_addr_in),
      .addr_out  (vec_addr_out)
   );

   // --------------------------------------------------------------------
   // read port, one cycle late
   // --------------------------------------------------------------------
   always_ff @(posedge clock_in)
   begin
      if (!rst_b_in)
         rd_q <= `FGS_RST_BYTE;
      else if (bus_in.rd)
         case (bus_in.addr)
            `FGS_DIV_ADDR:  rd_q <= {divisor_loaded_flag_q, div_q};
            `FGS_OPT_ADDR:  rd_q <= opt_q;
            `FGS_CFG_ADDR:  rd_q <= {2'b00, key_access_bit_q, 5'b00000};
            `FGS_PROT_ADDR: rd_q <= prot_q;
            `FGS_STAT_ADDR: rd_q <= {cbef_q, 1'b0, pviol_q, accerr_q,
                                     1'b0, seq_busy_in, 2'b00};
            `FGS_CMD_ADDR:  rd_q <= cmd_q.cmd;
            default:        rd_q <= 8'h00;
         endcase
      else
         rd_q <= 8'h00;
   end

   // outputs
   assign rd_data_out     = rd_q;
   assign seq_cmd_out     = launch_cmd_q;
   assign seq_launch_out  = launch_q;
   assign seq_abort_out   = abort_q;
   assign secure_out      = secured;
   assign prot_active_out = prot_en;

endmodule

// ### testbench/fgs_guard_chk.sv
// assertions on the flash guard ports
// assumes it is bound onto every fgs_guard instance
module fgs_guard_chk
(
   // clock and reset
   input wire logic                 clock_in,
   input wire logic                 rst_b_in,
   // watched ports
   input wire fgs_pkg::fgs_bus_type bus_in,
   input wire logic                 mem_block_out,
   input wire fgs_pkg::fgs_cmd_type seq_cmd_out,
   input wire logic                 seq_launch_out,
   input wire logic                 seq_abort_out,
   input wire logic                 seq_busy_in,
   input wire logic                 stop_in,
   input wire logic                 vec_fetch_in,
   input wire logic [15:0]          vec_addr_in,
   input wire logic [15:0]          vec_addr_out,
   input wire logic                 secure_out,
   input wire logic                 prot_active_out
);
   import fgs_pkg::*;
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_b_in);
   // ------------------------------------------------------------------
   // command protocol
   // ------------------------------------------------------------------
   AST_LAUNCH: assert property (
      seq_launch_out |-> $past(bus_in.wr) && $past(bus_in.wdata[7])
         && $past(bus_in.addr) == 16'h1825)
      else $error("launch without launching write");
   AST_CODE: assert property (
      seq_launch_out |-> seq_cmd_out.cmd inside
         {8'h05, 8'h20, 8'h25, 8'h40, 8'h41})
      else $error("launch of illegal code");
   AST_BUSY: assert property (
      seq_busy_in |-> !seq_launch_out)
      else $error("launch while sequencer busy");
   AST_ABORT: assert property (
      stop_in && seq_busy_in |=> seq_abort_out)
      else $error("stop while busy not aborted");
   // ------------------------------------------------------------------
   // security and vectors
   // ------------------------------------------------------------------
   AST_BLOCK: assert property (
      secure_out && (bus_in.rd || bus_in.wr) && bus_in.addr >= 16'h8000
         && (bus_in.from_debug || !bus_in.exec_secure) |-> mem_block_out)
      else $error("untrusted access not blocked");
   AST_OPEN: assert property (
      !secure_out |-> !mem_block_out)
      else $error("access blocked while unsecured");
   AST_HOLD: assert property (
      !secure_out |=> !secure_out)
      else $error("security came back before reset");
   AST_VRST: assert property (
      vec_fetch_in && vec_addr_in[15:1] == 15'h7fff
         |=> vec_addr_out == $past(vec_addr_in))
      else $error("reset vector redirected");
   AST_VOFS: assert property (
      vec_fetch_in
         |=> ((vec_addr_out ^ $past(vec_addr_in)) & 16'h01ff) == 16'h0000)
      else $error("vector offset lost");
   AST_VOFF: assert property (
      vec_fetch_in && !prot_active_out
         |=> vec_addr_out == $past(vec_addr_in))
      else $error("redirect without protection");
endmodule

bind fgs_guard fgs_guard_chk chk_i (.*);

// ### testbench/fgs_seq_model.sv
// flash sequencer stand-in: busy for a while after each launch
// assumes one-cycle launch and abort pulses from the guard
module fgs_seq_model
#(
   parameter int BUSY_CYC = 20
)
(
   // clock and reset
   input  wire logic       clock_in,
   input  wire logic       rst_b_in,
   // from the guard; blank_good_in from the bench
   input  wire logic       launch_in,
   input  wire logic       abort_in,
   input  wire logic [7:0] cmd_in,
   input  wire logic       blank_good_in,
   // to the guard
   output logic            busy_out,
   output logic            done_out,
   output logic            blank_ok_out
);
   logic [7:0] cnt_q;
   // count down; abort drops busy with no done, result scrambled off done
   always_ff @(posedge clock_in)
   begin
      done_out <= 1'b0;
      blank_ok_out <= ~blank_ok_out;
      if (!rst_b_in || abort_in)
      begin
         cnt_q <= 8'h00;
         blank_ok_out <= 1'b0;
      end
      else if (launch_in)
         cnt_q <= 8'(BUSY_CYC);
      else if (cnt_q != 8'h00)
      begin
         cnt_q <= cnt_q - 8'h01;
         done_out <= (cnt_q == 8'h01);
         if (cnt_q == 8'h01)
            blank_ok_out <= blank_good_in && cmd_in == 8'h05;
      end
   end
   assign busy_out = (cnt_q != 8'h00);
endmodule

// ### testbench/tb_fgs_guard.sv
// self-checking bench for the flash guard
// assumes the sequencer stand-in and the bound checker
module tb_fgs_guard import fgs_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock_in = 0, rst_b_in = 0, stop_in = 0, vf = 0, dbg = 0, good = 0;
   logic busy, done, bok, launch, abort, sec, pact, blk, ob;
   logic [7:0] rdat, nvp = 8'hfc, nvo = 8'h83;
   logic [15:0] va = 16'h0000, vo;
   fgs_bus_type bus = '0;
   fgs_cmd_type cmd;
   int bad_count = 0, n_compared = 0;
   always #12.5 clock_in = ~clock_in;
   fgs_guard dut (.clock_in, .rst_b_in, .bus_in(bus), .rd_data_out(rdat),
      .mem_block_out(blk), .nv_prot_in(nvp), .nv_opt_in(nvo),
      .nv_key_in(64'h8877665544332211), .seq_cmd_out(cmd),
      .seq_launch_out(launch), .seq_abort_out(abort), .seq_busy_in(busy),
      .seq_done_in(done), .blank_ok_in(bok), .stop_in, .vec_fetch_in(vf),
      .vec_addr_in(va), .vec_addr_out(vo), .secure_out(sec),
      .prot_active_out(pact));
   fgs_seq_model #(.BUSY_CYC(20)) sq (.clock_in, .rst_b_in,
      .launch_in(launch), .abort_in(abort), .cmd_in(cmd.cmd),
      .blank_good_in(good), .busy_out(busy), .done_out(done),
      .blank_ok_out(bok));
   task chk(input string n, input logic [31:0] e, g);
      n_compared++;
      if (g !== e)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   // one bus cycle; ob holds the block flag, rdat the read data after
   task cyc(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge clock_in);
      bus <= '{a, d, w, !w, dbg, !dbg};
      #1 ob = blk;
      @(posedge clock_in);
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      #1;
   endtask
   // array write, second write, status write, then clear the flags
   task run(input logic [15:0] a2, a, input logic [7:0] c, s,
            input logic l, input logic [1:0] e);
      cyc(1, a, 8'h5a);
      cyc(1, a2, c);
      cyc(1, 16'h1825, s);
      chk("launch", l, launch);
      if (l)
         chk("cmd", {c, a, 8'h5a}, cmd);
      cyc(0, 16'h1825, 0);
      chk("flags", e, rdat[5:4]);
      repeat (25) @(posedge clock_in);
      cyc(1, 16'h1825, 8'h30);
   endtask
   task t_stop;
      cyc(1, 16'h9000, 0);
      cyc(1, 16'h1826, 8'h40);
      cyc(1, 16'h1825, 8'h80);
      cyc(1, 16'h9000, 0);
      cyc(0, 16'h1825, 0);
      chk("busy_err", 1, rdat[4]);
      cyc(1, 16'h1825, 8'h30);
      @(posedge clock_in);
      stop_in <= 1'b1;
      @(posedge clock_in);
      #1 chk("abort", 1, abort);
      @(posedge clock_in);
      stop_in <= 1'b0;
      cyc(0, 16'h1825, 0);
      chk("stop_err", 1, rdat[4]);
      cyc(1, 16'h1825, 8'h30);
   endtask
   // key entry, bytes ascending with idle cycles between
   task keys(input logic d);
      dbg = d;
      cyc(1, 16'h1823, 8'h20);
      for (int i = 0; i < 8; i++)
         cyc(1, 16'(16'hffb0 + i), 8'(8'h11 * (i + 1)));
      cyc(1, 16'h1823, 8'h00);
      dbg = 0;
   endtask
   task vec(input logic [15:0] a, e);
      @(posedge clock_in);
      vf <= 1'b1;
      va <= a;
      @(posedge clock_in);
      vf <= 1'b0;
      #1 chk("vec", e, vo);
   endtask
   task wrap_up;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge clock_in);
      rst_b_in <= 1'b1;
      repeat (2) @(posedge clock_in);
      cyc(1, 16'h9000, 0);
      cyc(0, 16'h1825, 0);
      chk("no_div", 1, rdat[4]);
      cyc(1, 16'h1825, 8'h30);
      cyc(1, 16'h1820, 8'h13);
      cyc(0, 16'h1820, 0);
      chk("divisor_loaded_flag", 1, rdat[7]);
      run(16'h1826, 16'h9000, 8'h20, 8'h80, 1, 2'b00);
      run(16'h1826, 16'h9000, 8'h05, 8'h80, 1, 2'b00);
      run(16'h1826, 16'h9000, 8'h25, 8'h80, 1, 2'b00);
      run(16'h1826, 16'h9000, 8'h40, 8'h80, 1, 2'b00);
      run(16'h1826, 16'h9000, 8'h41, 8'h80, 0, 2'b10);
      run(16'h1826, 16'hfe00, 8'h20, 8'h80, 0, 2'b10);
      run(16'h1826, 16'hfdff, 8'h20, 8'h80, 1, 2'b00);
      run(16'h1826, 16'h9000, 8'h21, 8'h80, 0, 2'b01);
      run(16'h1826, 16'h9000, 8'h20, 8'h00, 0, 2'b01);
      run(16'h9001, 16'h9000, 8'h20, 8'h80, 0, 2'b01);
      run(16'h1824, 16'h9000, 8'h20, 8'h80, 0, 2'b01);
      dbg = 1;
      run(16'h1826, 16'h9000, 8'h20, 8'h80, 0, 2'b01);
      run(16'h1826, 16'h9000, 8'h05, 8'h80, 1, 2'b00);
      cyc(0, 16'h9000, 0);
      dbg = 0;
      chk("blocked", 1, ob);
      t_stop;
      vec(16'hffe0, 16'hfde0);
      vec(16'hfffe, 16'hfffe);
      chk("prot_on", 1, pact);
      keys(1);
      chk("dbg_key", 1, sec);
      keys(0);
      chk("key", 0, sec);
      dbg = 1;
      cyc(0, 16'h9000, 0);
      dbg = 0;
      chk("open", 0, ob);
      @(posedge clock_in);
      rst_b_in <= 1'b0;
      nvp <= 8'hff;
      nvo <= 8'h03;
      good <= 1'b1;
      repeat (2) @(posedge clock_in);
      rst_b_in <= 1'b1;
      repeat (2) @(posedge clock_in);
      #1 chk("resecured", 1, sec);
      chk("prot_off", 0, pact);
      vec(16'hffe0, 16'hffe0);
      keys(0);
      chk("no_backdoor_key_enable", 1, sec);
      cyc(1, 16'h1825, 8'h30);
      cyc(1, 16'h1820, 8'h13);
      run(16'h1826, 16'h9000, 8'h05, 8'h80, 1, 2'b00);
      chk("blank", 0, sec);
      wrap_up;
   end
   initial
   begin
      #(25 * 5000);
      bad_count++;
      wrap_up;
   end
endmodule
